// ==== src/cms_core_state.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cms_params.svh"

module cms_core_state
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  output logic       [1:0] exec_state,
  output logic             fault_pulse,
  output logic             irq_admit
);

  cms_pkg::cms_state_t r;
  cms_pkg::cms_state_t next_r;

  // ==========================================================
  // bus decode helpers
  logic        wr_acc;
  logic        rd_acc;
  logic        user_lvl;
  logic        use_psp;
  logic [31:0] sp_view;
  logic [31:0] psr_view;
  logic [8:0]  req_num;
  logic [8:0]  req_prio;
  logic        irq_ok;
  logic        setup_ph;
  logic        dec_hit;
  logic        dec_open;
  logic        dec_locked;
  logic [31:0] dec_rdata;

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // user level only exists in thread mode; handler is always privileged
  assign user_lvl = ~r.handler & r.modectl[0];
  assign use_psp  = ~r.handler & r.modectl[0] & r.modectl[1];
  assign sp_view  = (use_psp ? r.process_stack_pointer_reg : r.main_stack_pointer_reg) & `CMS_SP_ALIGN;
  // bit 24 forced so a PSR or EXEC read never shows it cleared
  assign psr_view = r.psr | `CMS_COMPACT_BIT;
  assign req_num  = pwdata[8:0];
  assign req_prio = pwdata[24:16];

  // ==========================================================
  // interrupt admission check, request number and priority in pwdata
  always_comb
  begin
    irq_ok = 1'b1;
    if (r.fmask)
      irq_ok = (req_num == `CMS_NMI_NUM);
    else if (r.gmask)
      irq_ok = (req_num == `CMS_NMI_NUM) || (req_num == `CMS_HARDFAULT_NUM);
    else if ((r.prio != 9'h000) && (req_prio >= r.prio))
      irq_ok = (req_num == `CMS_NMI_NUM) || (req_num == `CMS_HARDFAULT_NUM);
  end

  // ==========================================================
  // next state: register writes, events, faults and read data
  always_comb
  begin
    next_r         = r;
    next_r.fault   = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.prdata  = 32'h00000000;
    // answer registered off the setup phase so it stands at the access edge
    if (setup_ph)
    begin
      next_r.pslverr = dec_locked | ~dec_hit;
      if (!pwrite && !dec_locked)
        next_r.prdata = dec_rdata;
    end
    // accesses locked out at user level leave the state alone and pulse the fault
    if ((wr_acc | rd_acc) && dec_locked)
      next_r.fault = 1'b1;
    else if (wr_acc)
    begin
      if (paddr == `CMS_OFF_GPR_SEL)
        next_r.gpr_sel = pwdata[3:0];
      else if (paddr == `CMS_OFF_GPR_DATA)
      begin
        // slot 13 is the banked stack pointer, 15 the program counter
        if (r.gpr_sel == 4'hD)
        begin
          if (use_psp)
            next_r.process_stack_pointer_reg = pwdata & `CMS_SP_ALIGN;
          else
            next_r.main_stack_pointer_reg = pwdata & `CMS_SP_ALIGN;
        end
        else if (r.gpr_sel == 4'hF)
          next_r.pc = pwdata & `CMS_PC_ALIGN;
        else
          next_r.gpr[r.gpr_sel] = pwdata;
      end
      else if (paddr == `CMS_OFF_MSP)
        next_r.main_stack_pointer_reg = pwdata & `CMS_SP_ALIGN;
      else if (paddr == `CMS_OFF_PSP)
        next_r.process_stack_pointer_reg = pwdata & `CMS_SP_ALIGN;
      else if (paddr == `CMS_OFF_LINK)
        next_r.gpr[14] = pwdata;
      else if (paddr == `CMS_OFF_PC)
        next_r.pc = pwdata & `CMS_PC_ALIGN;
      else if (paddr == `CMS_OFF_PSR)
      begin
        // joint write; clearing the compact bit faults, bit stays set
        next_r.psr = (pwdata & (`CMS_FLAGS_MASK | `CMS_EXCNUM_MASK | `CMS_EXEC_MASK))
                     | `CMS_COMPACT_BIT;
        if (!pwdata[`CMS_COMPACT_POS])
          next_r.fault = 1'b1;
      end
      else if (paddr == `CMS_OFF_FLAGS)
        next_r.psr = (r.psr & ~`CMS_FLAGS_MASK) | (pwdata & `CMS_FLAGS_MASK);
      else if (paddr == `CMS_OFF_EXCNUM)
        next_r.psr = (r.psr & ~`CMS_EXCNUM_MASK) | (pwdata & `CMS_EXCNUM_MASK);
      else if (paddr == `CMS_OFF_EXEC)
      begin
        next_r.psr = (r.psr & ~`CMS_EXEC_MASK) | (pwdata & `CMS_EXEC_MASK);
        if (!pwdata[`CMS_COMPACT_POS])
          next_r.fault = 1'b1;
      end
      else if (paddr == `CMS_OFF_GMASK)
        next_r.gmask = pwdata[0];
      else if (paddr == `CMS_OFF_FMASK)
        next_r.fmask = pwdata[0];
      else if (paddr == `CMS_OFF_PRIO)
        next_r.prio = pwdata[8:0];
      else if (paddr == `CMS_OFF_MODECTL)
      begin
        next_r.modectl[0] = pwdata[0];
        next_r.modectl[1] = r.handler ? 1'b0 : pwdata[1];
      end
      else if (paddr == `CMS_OFF_EVENT)
      begin
        // instruction-side events: call, entry, return, illegal forms
        if (pwdata[2:0] == `CMS_EV_CALL)
          next_r.gpr[14] = r.pc + 32'h00000004;
        else if (pwdata[2:0] == `CMS_EV_ENTRY)
        begin
          next_r.handler    = 1'b1;
          next_r.saved_exc  = r.psr[8:0];
          next_r.psr[8:0]   = pwdata[16:8];
        end
        else if (pwdata[2:0] == `CMS_EV_RETURN)
        begin
          if (!r.handler)
            next_r.fault = 1'b1;
          else
          begin
            next_r.handler  = (r.saved_exc != 9'h000);
            next_r.psr[8:0] = r.saved_exc;
            next_r.saved_exc = 9'h000;
          end
        end
        else if (pwdata[2:0] == `CMS_EV_FULLWIDTH)
          next_r.fault = 1'b1;
        else if (pwdata[2:0] == `CMS_EV_RESTRICTED)
          next_r.fault = user_lvl;
        else if (pwdata[2:0] == `CMS_EV_NARROW_HIGH)
          // narrow instruction naming a high register
          next_r.fault = (pwdata[11:8] > `CMS_LOW_REG_LAST)
                         && (pwdata[11:8] <= `CMS_HIGH_REG_LAST);
      end
      // handler forces the stack select back to main
      if (next_r.handler)
        next_r.modectl[1] = 1'b0;
    end
  end

  // ==========================================================
  // setup-phase decode; address and direction are valid a cycle early,
  // which buys a registered answer without inserting a wait state
  always_comb
  begin
    dec_hit   = 1'b1;
    dec_open  = 1'b0;
    dec_rdata = 32'h00000000;
    if (paddr == `CMS_OFF_GPR_SEL)
    begin
      dec_open  = 1'b1;
      dec_rdata = {28'h0000000, r.gpr_sel};
    end
    else if (paddr == `CMS_OFF_GPR_DATA)
    begin
      dec_open = 1'b1;
      if (r.gpr_sel == `CMS_SP_SLOT)
        dec_rdata = sp_view;
      else if (r.gpr_sel == `CMS_PC_SLOT)
        dec_rdata = r.pc & `CMS_PC_ALIGN;
      else
        dec_rdata = r.gpr[r.gpr_sel];
    end
    else if (paddr == `CMS_OFF_MSP)
      dec_rdata = r.main_stack_pointer_reg & `CMS_SP_ALIGN;
    else if (paddr == `CMS_OFF_PSP)
      dec_rdata = r.process_stack_pointer_reg & `CMS_SP_ALIGN;
    else if (paddr == `CMS_OFF_LINK)
      dec_rdata = r.gpr[`CMS_LINK_SLOT];
    else if (paddr == `CMS_OFF_PC)
      dec_rdata = r.pc & `CMS_PC_ALIGN;
    else if (paddr == `CMS_OFF_PSR)
      dec_rdata = psr_view;
    else if (paddr == `CMS_OFF_FLAGS)
    begin
      dec_open  = 1'b1;
      dec_rdata = r.psr & `CMS_FLAGS_MASK;
    end
    else if (paddr == `CMS_OFF_EXCNUM)
      dec_rdata = r.psr & `CMS_EXCNUM_MASK;
    else if (paddr == `CMS_OFF_EXEC)
      dec_rdata = psr_view & (`CMS_EXEC_MASK | `CMS_COMPACT_BIT);
    else if (paddr == `CMS_OFF_GMASK)
      dec_rdata = {31'h00000000, r.gmask};
    else if (paddr == `CMS_OFF_FMASK)
      dec_rdata = {31'h00000000, r.fmask};
    else if (paddr == `CMS_OFF_PRIO)
      dec_rdata = {23'h000000, r.prio};
    else if (paddr == `CMS_OFF_MODECTL)
      dec_rdata = {30'h00000000, r.modectl};
    else if (paddr == `CMS_OFF_STATUS)
    begin
      // read only; user code may always look at its own state
      dec_open  = !pwrite;
      dec_hit   = !pwrite;
      dec_rdata = {30'h00000000, exec_state};
    end
    else if (paddr == `CMS_OFF_EVENT)
      dec_open = pwrite;
    else if (paddr == `CMS_OFF_IRQREQ)
      dec_open = 1'b1;
    else
      dec_hit = 1'b0;
    // user level keeps only its own window; unmapped slots are refused too
    dec_locked = user_lvl & ~dec_open;
  end

  // ==========================================================
  // state register; reset gives privileged thread on the main stack
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r     <= '0;
      r.psr <= `CMS_PSR_RESET;
    end
    else
      r <= next_r;
  end

  // ==========================================================
  // outputs; zero wait states, the answer was registered off the setup phase
  assign pready      = 1'b1;
  assign prdata      = r.prdata;
  assign pslverr     = r.pslverr;
  assign fault_pulse = r.fault;
  assign irq_admit   = wr_acc & (paddr == `CMS_OFF_IRQREQ) & irq_ok;
  assign exec_state  = r.handler ? cms_pkg::CMS_PRIV_HANDLER
                     : (r.modectl[0] ? cms_pkg::CMS_USER_THREAD
                                     : cms_pkg::CMS_PRIV_THREAD);

endmodule : cms_core_state
`default_nettype wire

// ==== pkg/cms_params.svh ====
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH
// register byte offsets on the apb slave
`define CMS_OFF_GPR_SEL     12'h000
`define CMS_OFF_GPR_DATA    12'h004
`define CMS_OFF_MSP         12'h008
`define CMS_OFF_PSP         12'h00C
`define CMS_OFF_LINK        12'h010
`define CMS_OFF_PC          12'h014
`define CMS_OFF_PSR         12'h018
`define CMS_OFF_FLAGS       12'h01C
`define CMS_OFF_EXCNUM      12'h020
`define CMS_OFF_EXEC        12'h024
`define CMS_OFF_GMASK       12'h028
`define CMS_OFF_FMASK       12'h02C
`define CMS_OFF_PRIO        12'h030
`define CMS_OFF_MODECTL     12'h034
`define CMS_OFF_EVENT       12'h038
`define CMS_OFF_STATUS      12'h03C
`define CMS_OFF_IRQREQ      12'h040
// field masks inside the status word, then alignment masks, register slots and exception numbers
`define CMS_FLAGS_MASK      32'hF8000000
`define CMS_EXCNUM_MASK     32'h000001FF
`define CMS_EXEC_MASK       32'h0600FC00
`define CMS_COMPACT_BIT     32'h01000000
`define CMS_COMPACT_POS     24
`define CMS_PSR_RESET       32'h01000000
`define CMS_SP_ALIGN        32'hFFFFFFFC
`define CMS_PC_ALIGN        32'hFFFFFFFE
`define CMS_LOW_REG_LAST    4'h7
`define CMS_HIGH_REG_LAST   4'hC
`define CMS_SP_SLOT         4'hD
`define CMS_LINK_SLOT       4'hE
`define CMS_PC_SLOT         4'hF
`define CMS_NMI_NUM         9'h002
`define CMS_HARDFAULT_NUM   9'h003
// event register command codes
`define CMS_EV_CALL         3'h1
`define CMS_EV_ENTRY        3'h2
`define CMS_EV_RETURN       3'h3
`define CMS_EV_FULLWIDTH    3'h4
`define CMS_EV_RESTRICTED   3'h5
`define CMS_EV_NARROW_HIGH  3'h6
`endif

// ==== pkg/cms_pkg.sv ====
package cms_pkg;
  typedef enum logic [1:0]
  {
    CMS_PRIV_THREAD,
    CMS_USER_THREAD,
    CMS_PRIV_HANDLER
  } cms_exec_state_t;

  typedef struct packed {
    logic [15:0][31:0] gpr;
    logic [3:0]        gpr_sel;
    logic [31:0]       main_stack_pointer_reg;
    logic [31:0]       process_stack_pointer_reg;
    logic [31:0]       pc;
    logic [31:0]       psr;
    logic [8:0]        saved_exc;
    logic              gmask;
    logic              fmask;
    logic [8:0]        prio;
    logic [1:0]        modectl;
    logic              handler;
    logic              fault;
    logic [31:0]       prdata;
    logic              pslverr;
  } cms_state_t;
endpackage : cms_pkg

// ==== verification/cms_core_state_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cms_params.svh"
// ====================
// port checker
module cms_core_state_sva
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  exec_state,
  input wire logic        fault_pulse,
  input wire logic        irq_admit
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access strobes; pready is tied high, so psel and penable mark the edge
  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && penable && !pwrite;
  wire logic ev = wr && paddr == `CMS_OFF_EVENT;
  wire logic pr = rd && exec_state != 2'h1;
  AST_STATES: assert property (
    exec_state != 2'h3) else $error("bad state");
  AST_ENTRY: assert property (
    ev && pwdata[2:0] == `CMS_EV_ENTRY && pwdata[16:8] != 9'h000 |=> exec_state == 2'h2)
    else $error("no handler");
  AST_FULLWIDTH: assert property (
    ev && pwdata[2:0] == `CMS_EV_FULLWIDTH |=> fault_pulse) else $error("no fault");
  AST_PRIV_READ: assert property (
    pr |=> !fault_pulse) else $error("privileged fault");
  AST_USER_BLOCK: assert property (
    wr && exec_state == 2'h1 && paddr == `CMS_OFF_MSP |-> pslverr ##1 fault_pulse)
    else $error("user write taken");
  AST_SP_ALIGN: assert property (
    pr && paddr == `CMS_OFF_MSP |-> prdata[1:0] == 2'h0) else $error("sp unaligned");
  AST_PC_ALIGN: assert property (
    pr && paddr == `CMS_OFF_PC |-> !prdata[0]) else $error("pc unaligned");
  AST_COMPACT: assert property (
    pr && paddr == `CMS_OFF_PSR |-> prdata[24]) else $error("compact bit low");
  AST_NMI: assert property (
    wr && paddr == `CMS_OFF_IRQREQ && pwdata[8:0] == `CMS_NMI_NUM |-> irq_admit)
    else $error("nmi blocked");
  AST_USER_SET: assert property (
    wr && paddr == `CMS_OFF_MODECTL && pwdata[0] && exec_state == 2'h0
    |=> exec_state == 2'h1) else $error("no user level");
endmodule : cms_core_state_sva
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cms_params.svh"
`define CMS_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
// ====================
// bench top
module tb;
  typedef struct {logic [31:0] e; logic [31:0] m; logic er, fl, ad, am;} cms_note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fault_pulse, irq_admit, hit, fl_exp, g, f;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, w;
  logic [1:0]  exec_state;
  logic [8:0]  t, num, pri;
  int          num_errors = 0;
  int          samples_checked = 0;
  cms_note_t   notes[$];
  cms_note_t   n;
  logic [11:0] rst_a[6] = '{`CMS_OFF_GMASK, `CMS_OFF_FMASK, `CMS_OFF_PRIO,
    `CMS_OFF_MODECTL, `CMS_OFF_STATUS, `CMS_OFF_PSR};
  logic [31:0] rst_e[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, `CMS_PSR_RESET};
  cms_core_state cms_core_state_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .exec_state(exec_state),
    .fault_pulse(fault_pulse), .irq_admit(irq_admit));
  // free running clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // one apb transfer; answer checked at its access edge, fault one cycle on
  task automatic xfer(input logic wn, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m, input logic er, input logic fl,
    input logic am, input logic ad);
    notes.push_back('{e, m, er, fl, ad, am});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wn;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic er, input logic fl);
    xfer(1'b1, a, d, 32'h0, 32'h0, er, fl, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic er, input logic fl);
    xfer(1'b0, a, 32'h0, e, m, er, fl, 1'b0, 1'b0);
  endtask : rd
  // admit decision: nmi first, then fault mask, hard fault, global mask, threshold
  function automatic logic admit(input logic gm, input logic fm, input logic [8:0] th,
    input logic [8:0] nm, input logic [8:0] pr);
    if (nm == `CMS_NMI_NUM) return 1'b1;
    if (fm) return 1'b0;
    if (nm == `CMS_HARDFAULT_NUM) return 1'b1;
    if (gm) return 1'b0;
    return !(th != 9'h000 && pr >= th);
  endfunction : admit
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // read data, error and admit are taken at the access edge itself;
  // the registered fault pulse stands in the cycle after that edge
  always @(posedge pclk)
  begin
    if (hit === 1'b1)
      `CMS_CHK(fault_pulse, fl_exp)
    hit = 1'b0;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && notes.size() > 0)
    begin
      n = notes.pop_front();
      if (n.m != 32'h0) `CMS_CHK(prdata & n.m, n.e & n.m)
      `CMS_CHK(pslverr, n.er)
      if (n.am) `CMS_CHK(irq_admit, n.ad)
      hit    = 1'b1;
      fl_exp = n.fl;
    end
  end
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    v = $urandom(95485);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_a[i]) rd(rst_a[i], rst_e[i], 32'hFFFFFFFF, 1'b0, 1'b0);
    rd(12'h0FC, 32'h0, 32'h0, 1'b1, 1'b0);
    for (int i = 0; i < 13; i++)
    begin
      v = $urandom();
      wr(`CMS_OFF_GPR_SEL, 32'(i), 1'b0, 1'b0);
      wr(`CMS_OFF_GPR_DATA, v, 1'b0, 1'b0);
      rd(`CMS_OFF_GPR_DATA, v, 32'hFFFFFFFF, 1'b0, 1'b0);
    end
    v = $urandom() | 32'h3;
    wr(`CMS_OFF_MSP, v, 1'b0, 1'b0);
    rd(`CMS_OFF_MSP, v & `CMS_SP_ALIGN, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_GPR_SEL, 32'hD, 1'b0, 1'b0);
    rd(`CMS_OFF_GPR_DATA, v & `CMS_SP_ALIGN, 32'hFFFFFFFF, 1'b0, 1'b0);
    w = $urandom() | 32'h1;
    wr(`CMS_OFF_PC, w, 1'b0, 1'b0);
    rd(`CMS_OFF_PC, w & `CMS_PC_ALIGN, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_EVENT, 32'(`CMS_EV_CALL), 1'b0, 1'b0);
    rd(`CMS_OFF_LINK, (w & `CMS_PC_ALIGN) + 32'h4, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_FLAGS, w, 1'b0, 1'b0);
    rd(`CMS_OFF_FLAGS, w, `CMS_FLAGS_MASK, 1'b0, 1'b0);
    rd(`CMS_OFF_PSR, (w & `CMS_FLAGS_MASK) | `CMS_PSR_RESET, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_EXEC, 32'h0, 1'b0, 1'b1);
    rd(`CMS_OFF_EXEC, `CMS_COMPACT_BIT, `CMS_COMPACT_BIT, 1'b0, 1'b0);
    wr(`CMS_OFF_EVENT, 32'(`CMS_EV_FULLWIDTH), 1'b0, 1'b1);
    wr(`CMS_OFF_EVENT, 32'(`CMS_EV_RESTRICTED), 1'b0, 1'b0);
    for (int r = 7; r < 14; r++)
      wr(`CMS_OFF_EVENT, 32'(r << 8) | 32'h6, 1'b0, r > 7 && r < 13);
    for (int i = 0; i < 16; i++)
    begin
      {g, f} = 2'($urandom());
      t = (i % 3 == 0) ? 9'h000 : 9'($urandom());
      num = (i % 4 == 0) ? `CMS_NMI_NUM : (i % 4 == 1) ? `CMS_HARDFAULT_NUM : 9'h010 + 9'(i);
      pri = 9'($urandom());
      wr(`CMS_OFF_GMASK, {31'h0, g}, 1'b0, 1'b0);
      wr(`CMS_OFF_FMASK, {31'h0, f}, 1'b0, 1'b0);
      wr(`CMS_OFF_PRIO, {23'h0, t}, 1'b0, 1'b0);
      xfer(1'b1, `CMS_OFF_IRQREQ, {7'h0, pri, 7'h0, num}, 32'h0, 32'h0, 1'b0, 1'b0, 1'b1,
        admit(g, f, t, num, pri));
    end
    wr(`CMS_OFF_PSP, w, 1'b0, 1'b0);
    wr(`CMS_OFF_MODECTL, 32'h3, 1'b0, 1'b0);
    rd(`CMS_OFF_STATUS, 32'h1, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_MSP, w, 1'b1, 1'b1);
    rd(`CMS_OFF_PRIO, 32'h0, 32'h0, 1'b1, 1'b1);
    wr(`CMS_OFF_EVENT, 32'(`CMS_EV_RESTRICTED), 1'b0, 1'b1);
    rd(`CMS_OFF_GPR_DATA, w & `CMS_SP_ALIGN, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_EVENT, 32'h502, 1'b0, 1'b0);
    rd(`CMS_OFF_STATUS, 32'h2, 32'hFFFFFFFF, 1'b0, 1'b0);
    rd(`CMS_OFF_EXCNUM, 32'h5, 32'hFFFFFFFF, 1'b0, 1'b0);
    wr(`CMS_OFF_MODECTL, 32'h3, 1'b0, 1'b0);
    rd(`CMS_OFF_MODECTL, 32'h1, 32'h3, 1'b0, 1'b0);
    wr(`CMS_OFF_EVENT, 32'(`CMS_EV_RETURN), 1'b0, 1'b0);
    rd(`CMS_OFF_STATUS, 32'h1, 32'hFFFFFFFF, 1'b0, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CMS_OFF_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0, 1'b0);
    repeat (2) @(posedge pclk);
    give_verdict();
  end
  // hang guard, well beyond the 147 transfers above
  initial
  begin
    #100us;
    num_errors++;
    give_verdict();
  end
endmodule : tb
bind cms_core_state cms_core_state_sva cms_core_state_sva_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .exec_state(exec_state), .fault_pulse(fault_pulse), .irq_admit(irq_admit));
`default_nettype wire
